// >>> inc/pcm_rx_pkg.sv
// Shared constants and types for the serial audio source and receiver ends
// ****************************************************************
// ****************************************************************
package pcm_rx_pkg;
	// ****************************************************************
	// Clocking and timing
	// ****************************************************************
	localparam int REF_PERIOD_NS     = 4;   // Local reference clock period
	localparam int BIT_PERIOD_NS     = 64;  // Bit clock period made by the source
	localparam int BIT_HALF_CYCLES   = BIT_PERIOD_NS / (2 * REF_PERIOD_NS);
	localparam int SYS_PERIOD_NS     = 16;  // System clock period made by the source
	localparam int SYS_HALF_CYCLES   = SYS_PERIOD_NS / (2 * REF_PERIOD_NS);
	localparam int IDLE_SYS_FRAMES   = 16;  // Frames with system clock low before internal
	localparam int SYS_DRIFT_MAX     = 5;   // Allowed system clocks of drift per frame
	localparam int BAD_FRAME_LIMIT   = 4;   // Bad frames tolerated before reinit
	localparam int CYCLES_PER_SAMPLE = 256; // Filter budget per input sample
	localparam int NORMAL_DELAY      = 22;  // Normal path group delay in samples
	localparam int LOW_LAT_DELAY     = 3;   // Low-latency path delay in whole samples
	localparam int RATIO_TOL_DIV     = 25;  // One part in 25 is four percent
	localparam int SAMPLE_W          = 32;  // Slot word width, MSB aligned
	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {RATIO_X8, RATIO_X4, RATIO_X2, RATIO_X1} interp_ratio_e;
	typedef enum logic {CLK_EXTERNAL, CLK_INTERNAL} clk_mode_e;
	// Bits of clock cycles per frame a frame may legally carry; 48 only while the external system clock is in use
	localparam logic [6:0] FRAME_BITS_32 = 7'h20;
	localparam logic [6:0] FRAME_BITS_48 = 7'h30;
	localparam logic [6:0] FRAME_BITS_64 = 7'h40;
	// Supported system clock multiples of the sample rate
	localparam int NUM_MULT = 12;
	localparam logic [11:0] SYS_MULT [NUM_MULT] = '{12'h040, 12'h080, 12'h0c0, 12'h100,
		12'h180, 12'h200, 12'h300, 12'h400, 12'h480, 12'h600, 12'h800, 12'hc00};
endpackage : pcm_rx_pkg

// >>> inc/pcm_link_if.sv
// Three-wire serial audio link plus optional system clock between the two ends
`timescale 1ns/1ns
interface pcm_link_if;
	logic sys_clock;        // System clock, held low when not supplied
	logic serial_bit_clock; // Bit clock
	logic lr_word_clock;    // Left/right word clock
	logic serial_data;      // Serial sample data
	// ****************************************************************
	// Party views
	// ****************************************************************
	modport source (output sys_clock, output serial_bit_clock, output lr_word_clock,
		output serial_data);
	modport sink (input sys_clock, input serial_bit_clock, input lr_word_clock,
		input serial_data);
endinterface : pcm_link_if

// >>> hdl/pcm_sample_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module pcm_sample_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 8
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_srst,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];  // Storage flops
	logic [AW-1:0]    wr_ptr;       // Next write slot
	logic [AW-1:0]    rd_ptr;       // Next read slot
	logic [AW:0]      count;        // Words held
	logic             push;         // Word accepted
	logic             pop;          // Word delivered

	assign o_in_ready  = (count != (AW+1)'(DEPTH));
	assign o_out_valid = (count != '0);
	assign o_out_data  = mem[rd_ptr];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	// Write side
	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	// Pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
		end
	end

	// Fill level
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			count <= '0;
		end else if (push && !pop) begin
			count <= count + 1'b1;
		end else if (pop && !push) begin
			count <= count - 1'b1;
		end
	end
endmodule : pcm_sample_fifo

// >>> hdl/pcm_audio_source.sv
// Source end: makes the clocks and serialises queued sample pairs
`timescale 1ns/1ns
module pcm_audio_source
	import pcm_rx_pkg::*;
#(
	parameter int SLOT_BITS  = 32,  // Bits per channel slot: 16, 24 or 32
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic                i_ref_clk,
	input  wire logic                i_srst,
	input  wire logic                i_format_select_pin, // Low I2S, high left-justified
	input  wire logic                i_sys_clock_enable,  // Drive system clock when high
	input  wire logic                i_sample_valid,
	output logic                     o_sample_ready,
	input  wire logic [SAMPLE_W-1:0] i_left,
	input  wire logic [SAMPLE_W-1:0] i_right,
	output logic                     o_underrun,          // Frame sent as zero
	pcm_link_if.source               link
);
	localparam int FRAME_BITS = 2 * SLOT_BITS;
	logic [7:0]            bit_div;    // Half bit period divider
	logic [7:0]            sys_div;    // Half system clock divider
	logic                  bclk;       // Bit clock level
	logic                  sclk;       // System clock level
	logic [6:0]            pos;        // Position of the next falling edge in frame
	logic [2*SAMPLE_W-1:0] frame_word; // Pair being sent
	logic                  lj_bit;     // Bit in left-justified order
	logic                  lj_prev;    // Same one bit earlier, for I2S
	logic                  lr;         // Word clock level
	logic                  data;       // Data level
	logic                  fifo_valid;
	logic [2*SAMPLE_W-1:0] fifo_data;
	logic                  fall;       // Bit clock falls this edge
	logic                  frame_start;
	logic                  left_slot;
	logic [5:0]            idx;

	// ****************************************************************
	// Sample queue
	// ****************************************************************
	pcm_sample_fifo #(.WIDTH(2*SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_ref_clk  (i_ref_clk),
		.i_srst     (i_srst),
		.i_in_valid (i_sample_valid),
		.o_in_ready (o_sample_ready),
		.i_in_data  ({i_left, i_right}),
		.o_out_valid(fifo_valid),
		.i_out_ready(frame_start),
		.o_out_data (fifo_data)
	);

	assign fall        = bclk && (bit_div == 8'(BIT_HALF_CYCLES-1));
	assign frame_start = fall && (pos == '0);
	assign left_slot   = (pos < 7'(SLOT_BITS));
	assign idx         = left_slot ? pos[5:0] : 6'(pos - 7'(SLOT_BITS));

	// Bit clock divider; data changes on the falling edge for the receiver
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			bit_div <= '0;
			bclk    <= 1'b0;
		end else if (bit_div == 8'(BIT_HALF_CYCLES-1)) begin
			bit_div <= '0;
			bclk    <= ~bclk;
		end else begin
			bit_div <= bit_div + 1'b1;
		end
	end

	// System clock, held low when disabled so the far end may go internal
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || !i_sys_clock_enable) begin
			sys_div <= '0;
			sclk    <= 1'b0;
		end else if (sys_div == 8'(SYS_HALF_CYCLES-1)) begin
			sys_div <= '0;
			sclk    <= ~sclk;
		end else begin
			sys_div <= sys_div + 1'b1;
		end
	end

	// Frame position and the pair in flight; an empty queue sends silence
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			pos        <= '0;
			frame_word <= '0;
			o_underrun <= 1'b0;
		end else if (fall) begin
			pos <= (pos == 7'(FRAME_BITS-1)) ? '0 : pos + 1'b1;
			if (frame_start) begin
				frame_word <= fifo_valid ? fifo_data : '0;
				o_underrun <= !fifo_valid;
			end
		end
	end

	// Serialiser: MSB first, I2S lags one bit and inverts the word clock
	always_comb begin
		if (frame_start) begin
			lj_bit = fifo_valid ? fifo_data[2*SAMPLE_W-1] : 1'b0;
		end else if (left_slot) begin
			lj_bit = frame_word[2*SAMPLE_W-1-idx];
		end else begin
			lj_bit = frame_word[SAMPLE_W-1-idx];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			lr      <= 1'b0;
			data    <= 1'b0;
			lj_prev <= 1'b0;
		end else if (fall) begin
			lj_prev <= lj_bit;
			if (i_format_select_pin) begin
				lr   <= left_slot;
				data <= lj_bit;
			end else begin
				lr   <= !left_slot;
				data <= lj_prev;
			end
		end
	end

	assign link.serial_bit_clock = bclk;
	assign link.sys_clock        = sclk;
	assign link.lr_word_clock    = lr;
	assign link.serial_data      = data;
endmodule : pcm_audio_source

// >>> hdl/pcm_audio_receiver.sv
// Receiver end: deserialises, manages system clock source, guards sync, filters
`timescale 1ns/1ns
module pcm_audio_receiver
	import pcm_rx_pkg::*;
#(
	parameter int HIST_DEPTH = NORMAL_DELAY + 1  // Sample pairs kept for the filters
) (
	input  wire logic                i_ref_clk,
	input  wire logic                i_srst,
	input  wire logic                i_format_select_pin, // Pin: low I2S, high LJ
	input  wire logic                i_filter_select_pin, // Pin: 0 normal, 1 low latency
	input  wire logic [1:0]          i_interp_ratio,      // x8, x4, x2, bypass
	pcm_link_if.sink                 link,
	output logic                     o_pair_valid,        // One-cycle pulse per frame
	output logic [SAMPLE_W-1:0]      o_pair_left,
	output logic [SAMPLE_W-1:0]      o_pair_right,
	output logic                     o_out_valid,         // Interpolated output strobe
	output logic [SAMPLE_W-1:0]      o_out_left,
	output logic [SAMPLE_W-1:0]      o_out_right,
	output logic                     o_muted,             // Bipolar zero forced
	output logic                     o_internal_clock,    // Internal system clock in use
	output logic [6:0]               o_bits_per_frame,
	output logic [11:0]              o_sys_per_frame,
	output logic                     o_ratio_valid,       // Ratio matches a supported one
	output logic [3:0]               o_ratio_index
);
	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [5:0] sync1;  // First stage, read only by the second
	logic [5:0] sync2;  // Stable copies
	logic       sck_s, bck_s, lr_s, din_s, fmt_lj, flt_low;
	logic       bck_q, sck_q;  // Previous levels for edge finding
	logic       bck_rise, sck_rise;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {link.sys_clock, link.serial_bit_clock, link.lr_word_clock,
				link.serial_data, i_format_select_pin, i_filter_select_pin};
			sync2 <= sync1;
		end
	end
	assign {sck_s, bck_s, lr_s, din_s, fmt_lj, flt_low} = sync2;

	// Edge finders on the stable copies
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			bck_q <= 1'b0;
			sck_q <= 1'b0;
		end else begin
			bck_q <= bck_s;
			sck_q <= sck_s;
		end
	end
	assign bck_rise = bck_s && !bck_q;
	assign sck_rise = sck_s && !sck_q;

	// ****************************************************************
	// Deserialiser
	// ****************************************************************
	// I2S is turned into the left-justified view by taking the word clock one
	// bit late and inverted, so one slot engine serves both formats.
	logic                lr_prev;     // Word clock at the previous rising edge
	logic                lr_eff;      // High during the left slot
	logic                lr_eff_q;
	logic [5:0]          bit_idx;     // Bit within slot
	logic [SAMPLE_W-1:0] shreg;       // Slot word being filled
	logic [SAMPLE_W-1:0] left_hold;   // Finished left word
	logic [6:0]          frame_bits;  // Bit clocks in the current frame
	logic                slot_change, left_start, pair_done;

	assign lr_eff      = fmt_lj ? lr_s : !lr_prev;
	assign slot_change = bck_rise && (lr_eff != lr_eff_q);
	assign left_start  = slot_change && lr_eff;
	assign pair_done   = left_start;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			lr_prev  <= 1'b0;
			lr_eff_q <= 1'b0;
			bit_idx  <= '0;
			shreg    <= '0;
		end else if (bck_rise) begin
			lr_prev  <= lr_s;
			lr_eff_q <= lr_eff;
			if (slot_change) begin
				bit_idx <= 6'h01;
				shreg   <= {din_s, {(SAMPLE_W-1){1'b0}}};
			end else if (bit_idx < 6'(SAMPLE_W)) begin
				// Shorter samples leave the low bits zero, keeping MSB alignment
				shreg[SAMPLE_W-1-bit_idx[4:0]] <= din_s;
				bit_idx <= bit_idx + 1'b1;
			end
		end
	end

	// Slot words out; right closes when the next left begins
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			left_hold    <= '0;
			o_pair_left  <= '0;
			o_pair_right <= '0;
			o_pair_valid <= 1'b0;
		end else begin
			o_pair_valid <= pair_done && !o_muted && !reinit;
			if (slot_change && !lr_eff) begin
				left_hold <= shreg;
			end
			if (pair_done) begin
				o_pair_left  <= left_hold;
				o_pair_right <= shreg;
			end
		end
	end

	// ****************************************************************
	// Frame measurement and clock supervision
	// ****************************************************************
	logic [11:0] sys_count;      // System clock edges this frame
	logic        sys_seen;       // Any system clock edge this frame
	logic [4:0]  idle_frames;    // Frames without system clock
	logic [2:0]  bad_frames;     // Consecutive malformed frames
	logic        seen_frame;     // A previous measurement exists
	logic        frame_ok, drift_bad, go_internal, go_external, reinit;
	logic [12:0] drift;

	function automatic logic [12:0] abs_diff(input logic [11:0] a, input logic [11:0] b);
		abs_diff = (a > b) ? 13'(a - b) : 13'(b - a);
	endfunction : abs_diff

	always_comb begin
		frame_ok = (frame_bits == FRAME_BITS_32) || (frame_bits == FRAME_BITS_64) ||
			((frame_bits == FRAME_BITS_48) && !o_internal_clock);
	end
	assign drift       = abs_diff(sys_count, o_sys_per_frame);
	assign drift_bad   = !o_internal_clock && seen_frame && (drift > 13'(SYS_DRIFT_MAX));
	assign go_internal = left_start && !o_internal_clock && !sys_seen &&
		(idle_frames == 5'(IDLE_SYS_FRAMES-1));
	assign go_external = o_internal_clock && sck_rise;
	// Malformed frames count up; the fifth in a row is one more than allowed
	assign reinit = go_internal || go_external || (left_start && (drift_bad ||
		(!frame_ok && bad_frames == 3'(BAD_FRAME_LIMIT))));

	// Bit clocks per frame, closed at each left slot start
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			frame_bits       <= '0;
			o_bits_per_frame <= '0;
			bad_frames       <= '0;
			seen_frame       <= 1'b0;
		end else if (left_start) begin
			frame_bits       <= 7'h01;
			o_bits_per_frame <= frame_bits;
			seen_frame       <= 1'b1;
			bad_frames       <= frame_ok ? '0 :
				(bad_frames == 3'(BAD_FRAME_LIMIT)) ? bad_frames : bad_frames + 1'b1;
		end else if (bck_rise && frame_bits != 7'h7f) begin
			frame_bits <= frame_bits + 1'b1;
		end
	end

	// System clock edges per frame and idle-frame count
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			sys_count       <= '0;
			sys_seen        <= 1'b0;
			idle_frames     <= '0;
			o_sys_per_frame <= '0;
		end else if (left_start) begin
			sys_count       <= '0;
			sys_seen        <= 1'b0;
			o_sys_per_frame <= sys_count;
			idle_frames     <= sys_seen ? '0 :
				(idle_frames == 5'(IDLE_SYS_FRAMES-1)) ? idle_frames : idle_frames + 1'b1;
		end else if (sck_rise) begin
			sys_count <= (sys_count == 12'hfff) ? sys_count : sys_count + 1'b1;
			sys_seen  <= 1'b1;
		end
	end

	// Clock source: external after reset, internal after a run of idle frames
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_internal_clock <= 1'b0;
		end else if (go_external) begin
			o_internal_clock <= 1'b0;
		end else if (go_internal) begin
			o_internal_clock <= 1'b1;
		end
	end

	// Mute at once on reinit; lift after one clean frame
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_muted <= 1'b1;
		end else if (reinit) begin
			o_muted <= 1'b1;
		end else if (left_start && frame_ok && !drift_bad) begin
			o_muted <= 1'b0;
		end
	end

	// Ratio detector: system clocks per frame against the table, four percent
	always_comb begin
		o_ratio_valid = 1'b0;
		o_ratio_index = '0;
		for (int k = 0; k < NUM_MULT; k++) begin
			if (18'(RATIO_TOL_DIV) * 18'(abs_diff(o_sys_per_frame, SYS_MULT[k])) <=
				18'(SYS_MULT[k])) begin
				o_ratio_valid = 1'b1;
				o_ratio_index = 4'(k);
			end
		end
	end

	// ****************************************************************
	// Interpolation filter
	// ****************************************************************
	// Delay lines only: the paths keep their group delays, while the response
	// shaping is held back to save area.
	logic [2*SAMPLE_W-1:0] hist [HIST_DEPTH];  // Newest pair in slot 0
	logic [8:0]            cyc;                 // Cycle within the sample budget
	logic [8:0]            step;                // Cycles between output points
	logic [2*SAMPLE_W-1:0] tap;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst || reinit) begin
			for (int k = 0; k < HIST_DEPTH; k++) begin
				hist[k] <= '0;                              // Bipolar zero
			end
		end else if (o_pair_valid) begin
			hist[0] <= {o_pair_left, o_pair_right};
			for (int k = 1; k < HIST_DEPTH; k++) begin
				hist[k] <= hist[k-1];
			end
		end
	end

	// Tap selected by the filter pin
	assign tap  = flt_low ? hist[LOW_LAT_DELAY] : hist[NORMAL_DELAY];
	assign step = 9'(CYCLES_PER_SAMPLE) >> (2'h3 - i_interp_ratio); // x8 shifts by 3, bypass 0

	// Budget counter restarts on each new sample and stops at 256
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			cyc <= 9'(CYCLES_PER_SAMPLE);
		end else if (o_pair_valid) begin
			cyc <= '0;
		end else if (cyc != 9'(CYCLES_PER_SAMPLE)) begin
			cyc <= cyc + 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_out_valid <= 1'b0;
			o_out_left  <= '0;
			o_out_right <= '0;
		end else begin
			o_out_valid <= (cyc != 9'(CYCLES_PER_SAMPLE)) && ((cyc & (step - 1'b1)) == '0);
			o_out_left  <= o_muted ? '0 : tap[2*SAMPLE_W-1:SAMPLE_W];
			o_out_right <= o_muted ? '0 : tap[SAMPLE_W-1:0];
		end
	end
endmodule : pcm_audio_receiver

// >>> sim/pcm_link_monitor.sv
// Checker watching the serial link and the receiver's result ports
`timescale 1ns/1ns
module pcm_link_monitor (
	input wire logic        i_ref_clk,
	input wire logic        i_srst,
	input wire logic        sys_clock,
	input wire logic        serial_bit_clock,
	input wire logic        lr_word_clock,
	input wire logic        serial_data,
	input wire logic        o_pair_valid,
	input wire logic        o_out_valid,
	input wire logic        o_muted,
	input wire logic        o_internal_clock,
	input wire logic [6:0]  o_bits_per_frame,
	input wire logic [31:0] o_out_left,
	input wire logic [31:0] o_out_right
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	// ****************************************************************
	// Sequences
	// ****************************************************************
	// Bit clock high for a full half period of eight reference cycles
	sequence bck_high;
		serial_bit_clock[*8] ##1 !serial_bit_clock;
	endsequence
	// Ratio is tied to x8 in the bench, so outputs come 32 cycles apart
	sequence out_burst;
		##2 o_out_valid ##32 o_out_valid;
	endsequence
	// ****************************************************************
	// Assertions
	// ****************************************************************
	data_edge_a: assert property ($changed(serial_data) |-> !serial_bit_clock)
		else $error("data moved while bit clock high");
	word_edge_a: assert property ($changed(lr_word_clock) |-> !serial_bit_clock)
		else $error("word clock moved while bit clock high");
	bit_half_a: assert property ($rose(serial_bit_clock) |-> bck_high)
		else $error("bit clock half period wrong");
	mute_zero_a: assert property (o_muted && $past(o_muted) |->
		o_out_left == 32'h0 && o_out_right == 32'h0)
		else $error("output not zero while muted");
	pair_unmuted_a: assert property (o_pair_valid |-> !o_muted)
		else $error("pair delivered while muted");
	pair_pulse_a: assert property (o_pair_valid |=> !o_pair_valid)
		else $error("pair strobe longer than a cycle");
	frame_bits_a: assert property (o_pair_valid |-> o_bits_per_frame == 7'h40)
		else $error("frame length not 64 bits");
	out_burst_a: assert property (o_pair_valid |-> out_burst)
		else $error("interpolated strobes mistimed");
	ext_return_a: assert property ($rose(sys_clock) && o_internal_clock |->
		##[1:16] !o_internal_clock)
		else $error("internal clock kept with system clock present");
endmodule : pcm_link_monitor

// >>> sim/tb.sv
// Bench joining the source and receiver ends over one link
`timescale 1ns/1ns
module tb;
	import pcm_rx_pkg::*;
	typedef struct {logic f; logic [31:0] l; logic [31:0] r;} row_s;
	logic        ref_clk = 0, srst = 1, fmt = 0, sck_en = 1, s_valid = 0, s_ready;
	logic [31:0] s_left = 0, s_right = 0, gl, gr;
	logic        o_pair_valid, o_out_valid, o_muted, o_internal_clock;
	logic [31:0] o_pair_left, o_pair_right, o_out_left, o_out_right;
	logic [6:0]  o_bits_per_frame;
	logic        filter_select_pin = 0, under, o_ratio_valid;
	logic [3:0]  o_ratio_index;
	int          fail_count = 0, total_checks = 0, k;
	// Extreme two's complement values expose sign and bit order slips
	row_s rows [6] = '{'{0, 32'h80000001, 32'h7ffffffe}, '{0, 32'hffffffff, 32'h00000001},
		'{0, 32'h12345678, 32'hedcba987}, '{1, 32'h80000000, 32'h0000ffff},
		'{1, 32'h7fffffff, 32'hfffe0001}, '{1, 32'h00000001, 32'hc0000003}};
	always #2 ref_clk = ~ref_clk;
	pcm_link_if link ();
	pcm_audio_source i_pcm_audio_source (.i_ref_clk(ref_clk), .i_srst(srst),
		.i_format_select_pin(fmt), .i_sys_clock_enable(sck_en), .i_sample_valid(s_valid),
		.o_sample_ready(s_ready), .i_left(s_left), .i_right(s_right), .o_underrun(under),
		.link(link));
	// Ratio tied to x8; the filter pin is driven by the bench
	pcm_audio_receiver i_pcm_audio_receiver (.i_ref_clk(ref_clk), .i_srst(srst),
		.i_format_select_pin(fmt), .i_filter_select_pin(filter_select_pin), .i_interp_ratio(2'h0),
		.link(link), .o_pair_valid, .o_pair_left, .o_pair_right, .o_out_valid,
		.o_out_left, .o_out_right, .o_muted, .o_internal_clock, .o_bits_per_frame,
		.o_sys_per_frame(), .o_ratio_valid, .o_ratio_index);
	pcm_link_monitor i_pcm_link_monitor (.i_ref_clk(ref_clk), .i_srst(srst),
		.sys_clock(link.sys_clock), .serial_bit_clock(link.serial_bit_clock),
		.lr_word_clock(link.lr_word_clock), .serial_data(link.serial_data), .o_pair_valid,
		.o_out_valid, .o_muted, .o_internal_clock, .o_bits_per_frame, .o_out_left,
		.o_out_right);
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic close_out;
		if (fail_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// Bounded wait; a timeout counts and ends the run
	task automatic expire(input string n, input int i, input int lim);
		if (i >= lim) begin
			chk(n, 1, 0);
			close_out();
		end
	endtask : expire
	// Entered on an edge; leaves valid high so pushes may follow back to back
	task automatic push(input logic [31:0] l, input logic [31:0] r);
		#1 s_valid = 1;
		s_left = l;
		s_right = r;
		for (k = 0; k < 3000; k++) begin
			@(posedge ref_clk);
			if (s_ready === 1) break;
		end
		expire("push", k, 3000);
	endtask : push
	// Zero pairs are idle frames of an empty queue and are skipped
	task automatic get_pair;
		for (k = 0; k < 5000; k++) begin
			@(posedge ref_clk);
			if (o_pair_valid === 1 && {o_pair_left, o_pair_right} !== 64'h0) break;
		end
		expire("pair", k, 5000);
		gl = o_pair_left;
		gr = o_pair_right;
	endtask : get_pair
	task automatic restart(input logic f);
		@(posedge ref_clk);
		#1 srst = 1;
		fmt = f;
		repeat (4) @(posedge ref_clk);
		#1 srst = 0;
		chk("muted", 1, o_muted);
		for (k = 0; k < 20000 && o_muted !== 0; k++) @(posedge ref_clk);
		expire("unmute", k, 20000);
	endtask : restart
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (10) @(posedge ref_clk);
		#1 srst = 0;
		chk("intclk", 0, o_internal_clock);
		// Row loop: each format resets both ends, then one pair crosses per row
		foreach (rows[i]) begin
			if (i == 0 || rows[i].f !== rows[i-1].f) restart(rows[i].f);
			push(rows[i].l, rows[i].r);
			#1 s_valid = 0;
			get_pair();
			chk("left", rows[i].l, gl);
			chk("right", rows[i].r, gr);
		end
		// Fill the queue just after a pop so all eight must fit, then drain
		for (k = 0; k < 5000 && o_pair_valid !== 1; k++) @(posedge ref_clk);
		expire("sync", k, 5000);
		for (int j = 1; j <= 8; j++) push(32'h11111111 * j, ~(32'h11111111 * j));
		#1 s_valid = 0;
		chk("full", 0, s_ready);
		filter_select_pin = 1; // Low-latency tap while the eight pairs arrive back to back
		for (int j = 1; j <= 8; j++) begin
			get_pair();
			chk("fifo", 32'h11111111 * j, gl);
		end
		// Three whole samples back from pair 8 is pair 5
		repeat (3) @(posedge ref_clk);
		chk("lowlat", 32'h55555555, o_out_left);
		chk("ratio", 32'h13, {o_ratio_valid, o_ratio_index});
		chk("underrun", 1, under);
		// Remove the system clock: internal clock after 16 idle frames
		#1 sck_en = 0;
		for (k = 0; k < 20000 && o_internal_clock !== 1; k++) @(posedge ref_clk);
		expire("internal", k, 20000);
		chk("idle", 1, k >= 15 * 1024 && k <= 17 * 1024);
		#1 sck_en = 1;
		for (k = 0; k < 2048 && o_internal_clock !== 0; k++) @(posedge ref_clk);
		chk("external", 0, o_internal_clock);
		close_out();
	end
endmodule : tb
